// ### hdl/gpifs_pkg.sv
// Package for the pin input-function multiplexer: register map, selector codes and carrier types.
// Assumes a 32-bit AXI4-Lite register port and five general-purpose pins.
package gpifs_pkg;

  localparam int unsigned PIN_COUNT = 5;
  localparam int unsigned SEL_WIDTH = 3;
  localparam int unsigned ADDR_WIDTH = 8;
  localparam int unsigned DATA_WIDTH = 32;

  // Register byte offsets.
  localparam logic [7:0] PIN0_FUNC_OFFSET = 8'h00;
  localparam logic [7:0] PIN1_FUNC_OFFSET = 8'h04;
  localparam logic [7:0] PIN2_FUNC_OFFSET = 8'h08;
  localparam logic [7:0] PIN3_FUNC_OFFSET = 8'h0c;
  localparam logic [7:0] PIN4_FUNC_OFFSET = 8'h10;
  localparam logic [7:0] PIN_DIR_OFFSET = 8'h14;
  localparam logic [7:0] PIN_STATUS_OFFSET = 8'h18;
  localparam logic [7:0] OUT_ENABLE_OFFSET = 8'h1c;
  localparam logic [7:0] REF_SELECT_OFFSET = 8'h20;

  // Reset values.
  localparam logic [2:0] SEL_RESET = 3'h0;
  localparam logic [4:0] DIR_RESET = 5'h00;
  localparam logic [4:0] OE_RESET = 5'h1f;

  // Selector codes.
  localparam logic [2:0] SEL_STATUS = 3'h0;
  localparam logic [2:0] SEL_OUT_ENABLE = 3'h1;
  localparam logic [2:0] SEL_REF_SELECT = 3'h5;

  // Pins that may carry a manual reference select.
  localparam int unsigned FIRST_PLL_PIN = 2;
  localparam int unsigned SECOND_PLL_PIN = 3;

  // Direction bit value for an input pin.
  localparam logic DIR_INPUT = 1'b0;

  // AXI4-Lite responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    GPIFS_W_IDLE = 2'h1,
    GPIFS_W_RESP = 2'h2
  } gpifs_wstate_t;

  typedef struct packed {
    logic [PIN_COUNT-1:0] pin_input_status_bit;
    logic [PIN_COUNT-1:0] clock_output_enable;
    logic                 first_pll_manual_ref_select;
    logic                 second_pll_manual_ref_select;
  } gpifs_fabric_t;

endpackage

// ### hdl/gpifs_pin_route.sv
// One pin's input-function decode.
// Assumes the selector and direction are stable register values.
`timescale 1ns/1ns
`default_nettype none
module gpifs_pin_route #(
  parameter bit HAS_REF_SELECT = 1'b0
) (
  // Configuration.
  input  wire logic [2:0] sel_in,
  input  wire logic       dir_in,
  // Pin level and hold values.
  input  wire logic       pin_in,
  input  wire logic       status_hold_in,
  input  wire logic       oe_hold_in,
  input  wire logic       ref_hold_in,
  // Routed values.
  output logic            status_out,
  output logic            oe_out,
  output logic            ref_out
);
  logic as_input;

  assign as_input   = (dir_in == gpifs_pkg::DIR_INPUT);
  assign status_out = (as_input && sel_in == gpifs_pkg::SEL_STATUS) ? pin_in : status_hold_in;
  assign oe_out     = (as_input && sel_in == gpifs_pkg::SEL_OUT_ENABLE) ? pin_in : oe_hold_in;
  assign ref_out    = (HAS_REF_SELECT && as_input && sel_in == gpifs_pkg::SEL_REF_SELECT) ?
                      pin_in : ref_hold_in;
endmodule
`default_nettype wire

// ### hdl/gpifs_top.sv
// Input-function multiplexer for general-purpose pins 0 to 4 with an AXI4-Lite register port.
// Assumes pin levels synchronous to clk_in and a single-beat AXI4-Lite master.
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module gpifs_top (
  // Clock and reset.
  input  wire logic                              clk_in,
  input  wire logic                              rst_n_in,
  // AXI4-Lite write address and data.
  input  wire logic [gpifs_pkg::ADDR_WIDTH-1:0]  s_axi_awaddr_in,
  input  wire logic                              s_axi_awvalid_in,
  output logic                                   s_axi_awready_out,
  input  wire logic [gpifs_pkg::DATA_WIDTH-1:0]  s_axi_wdata_in,
  input  wire logic [3:0]                        s_axi_wstrb_in,
  input  wire logic                              s_axi_wvalid_in,
  output logic                                   s_axi_wready_out,
  // AXI4-Lite write response.
  output logic [1:0]                             s_axi_bresp_out,
  output logic                                   s_axi_bvalid_out,
  input  wire logic                              s_axi_bready_in,
  // AXI4-Lite read.
  input  wire logic [gpifs_pkg::ADDR_WIDTH-1:0]  s_axi_araddr_in,
  input  wire logic                              s_axi_arvalid_in,
  output logic                                   s_axi_arready_out,
  output logic [gpifs_pkg::DATA_WIDTH-1:0]       s_axi_rdata_out,
  output logic [1:0]                             s_axi_rresp_out,
  output logic                                   s_axi_rvalid_out,
  input  wire logic                              s_axi_rready_in,
  // Pins and routed functions.
  input  wire logic [gpifs_pkg::PIN_COUNT-1:0]   pin_in,
  output gpifs_pkg::gpifs_fabric_t               fabric_out
);
  localparam int unsigned N = gpifs_pkg::PIN_COUNT;

  logic [2:0]              sel_reg [N];
  logic [N-1:0]            dir_reg;
  gpifs_pkg::gpifs_fabric_t fabric_next;
  logic [N-1:0]            ref_bit;

  gpifs_pkg::gpifs_wstate_t wstate_reg;
  logic                    aw_held_reg;
  logic                    w_held_reg;
  logic [7:0]              awaddr_reg;
  logic [31:0]             wdata_reg;
  logic [3:0]              wstrb_reg;
  logic                    do_write;
  logic [7:0]              wa;

  // Per-pin decode.
  for (genvar i = 0; i < N; i++) begin : g_pin
    gpifs_pin_route #(
      .HAS_REF_SELECT ((i == gpifs_pkg::FIRST_PLL_PIN) || (i == gpifs_pkg::SECOND_PLL_PIN))
    ) u_route (
      .sel_in         (sel_reg[i]),
      .dir_in         (dir_reg[i]),
      .pin_in         (pin_in[i]),
      .status_hold_in (fabric_out.pin_input_status_bit[i]),
      .oe_hold_in     (fabric_out.clock_output_enable[i]),
      .ref_hold_in    ((i == gpifs_pkg::FIRST_PLL_PIN) ? fabric_out.first_pll_manual_ref_select :
                       fabric_out.second_pll_manual_ref_select),
      .status_out     (fabric_next.pin_input_status_bit[i]),
      .oe_out         (fabric_next.clock_output_enable[i]),
      .ref_out        (ref_bit[i])
    );
  end

  assign fabric_next.first_pll_manual_ref_select  = ref_bit[gpifs_pkg::FIRST_PLL_PIN];
  assign fabric_next.second_pll_manual_ref_select = ref_bit[gpifs_pkg::SECOND_PLL_PIN];

  // Routed functions are registered so outputs come from flip-flops.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fabric_out.pin_input_status_bit         <= '0;
      fabric_out.clock_output_enable          <= gpifs_pkg::OE_RESET;
      fabric_out.first_pll_manual_ref_select  <= 1'b0;
      fabric_out.second_pll_manual_ref_select <= 1'b0;
    end else begin
      fabric_out <= fabric_next;
    end
  end

  // Write channel: address and data taken in either order, response after both.
  assign wa       = aw_held_reg ? awaddr_reg : s_axi_awaddr_in;
  assign do_write = (wstate_reg == gpifs_pkg::GPIFS_W_IDLE) &&
                    (aw_held_reg || (s_axi_awvalid_in && s_axi_awready_out)) &&
                    (w_held_reg || (s_axi_wvalid_in && s_axi_wready_out));

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wstate_reg        <= gpifs_pkg::GPIFS_W_IDLE;
      aw_held_reg       <= 1'b0;
      w_held_reg        <= 1'b0;
      awaddr_reg        <= 8'h00;
      wdata_reg         <= 32'h0000_0000;
      wstrb_reg         <= 4'h0;
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out  <= 1'b1;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= gpifs_pkg::RESP_OKAY;
    end else begin
      case (wstate_reg)
        gpifs_pkg::GPIFS_W_IDLE: begin
          if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_held_reg       <= 1'b1;
            awaddr_reg        <= s_axi_awaddr_in;
            s_axi_awready_out <= 1'b0;
          end
          if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_held_reg       <= 1'b1;
            wdata_reg        <= s_axi_wdata_in;
            wstrb_reg        <= s_axi_wstrb_in;
            s_axi_wready_out <= 1'b0;
          end
          if (do_write) begin
            aw_held_reg       <= 1'b0;
            w_held_reg        <= 1'b0;
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out  <= 1'b0;
            s_axi_bvalid_out  <= 1'b1;
            s_axi_bresp_out   <= (wa <= gpifs_pkg::REF_SELECT_OFFSET && wa[1:0] == 2'h0) ?
                                 gpifs_pkg::RESP_OKAY : gpifs_pkg::RESP_SLVERR;
            wstate_reg        <= gpifs_pkg::GPIFS_W_RESP;
          end
        end
        gpifs_pkg::GPIFS_W_RESP: begin
          if (s_axi_bready_in) begin
            s_axi_bvalid_out  <= 1'b0;
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out  <= 1'b1;
            wstate_reg        <= gpifs_pkg::GPIFS_W_IDLE;
          end
        end
        default: begin
          wstate_reg <= gpifs_pkg::GPIFS_W_IDLE;
        end
      endcase
    end
  end

  // Register writes; byte lane 0 carries every writable field.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int k = 0; k < N; k++) begin
        sel_reg[k] <= gpifs_pkg::SEL_RESET;
      end
      dir_reg <= gpifs_pkg::DIR_RESET;
    end else if (do_write && (w_held_reg ? wstrb_reg[0] : s_axi_wstrb_in[0])) begin
      if (wa == gpifs_pkg::PIN0_FUNC_OFFSET) begin
        sel_reg[0] <= w_held_reg ? wdata_reg[2:0] : s_axi_wdata_in[2:0];
      end else if (wa == gpifs_pkg::PIN1_FUNC_OFFSET) begin
        sel_reg[1] <= w_held_reg ? wdata_reg[2:0] : s_axi_wdata_in[2:0];
      end else if (wa == gpifs_pkg::PIN2_FUNC_OFFSET) begin
        sel_reg[2] <= w_held_reg ? wdata_reg[2:0] : s_axi_wdata_in[2:0];
      end else if (wa == gpifs_pkg::PIN3_FUNC_OFFSET) begin
        sel_reg[3] <= w_held_reg ? wdata_reg[2:0] : s_axi_wdata_in[2:0];
      end else if (wa == gpifs_pkg::PIN4_FUNC_OFFSET) begin
        sel_reg[4] <= w_held_reg ? wdata_reg[2:0] : s_axi_wdata_in[2:0];
      end else if (wa == gpifs_pkg::PIN_DIR_OFFSET) begin
        dir_reg <= w_held_reg ? wdata_reg[N-1:0] : s_axi_wdata_in[N-1:0];
      end
    end
  end

  // Read channel: one-cycle answer after the address is taken.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0000_0000;
      s_axi_rresp_out   <= gpifs_pkg::RESP_OKAY;
    end else if (s_axi_rvalid_out) begin
      if (s_axi_rready_in) begin
        s_axi_rvalid_out  <= 1'b0;
        s_axi_arready_out <= 1'b1;
      end
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b1;
      s_axi_rresp_out   <= gpifs_pkg::RESP_OKAY;
      s_axi_rdata_out   <= 32'h0000_0000;
      if (s_axi_araddr_in == gpifs_pkg::PIN0_FUNC_OFFSET) begin
        s_axi_rdata_out[2:0] <= sel_reg[0];
      end else if (s_axi_araddr_in == gpifs_pkg::PIN1_FUNC_OFFSET) begin
        s_axi_rdata_out[2:0] <= sel_reg[1];
      end else if (s_axi_araddr_in == gpifs_pkg::PIN2_FUNC_OFFSET) begin
        s_axi_rdata_out[2:0] <= sel_reg[2];
      end else if (s_axi_araddr_in == gpifs_pkg::PIN3_FUNC_OFFSET) begin
        s_axi_rdata_out[2:0] <= sel_reg[3];
      end else if (s_axi_araddr_in == gpifs_pkg::PIN4_FUNC_OFFSET) begin
        s_axi_rdata_out[2:0] <= sel_reg[4];
      end else if (s_axi_araddr_in == gpifs_pkg::PIN_DIR_OFFSET) begin
        s_axi_rdata_out[N-1:0] <= dir_reg;
      end else if (s_axi_araddr_in == gpifs_pkg::PIN_STATUS_OFFSET) begin
        s_axi_rdata_out[N-1:0] <= fabric_out.pin_input_status_bit;
      end else if (s_axi_araddr_in == gpifs_pkg::OUT_ENABLE_OFFSET) begin
        s_axi_rdata_out[N-1:0] <= fabric_out.clock_output_enable;
      end else if (s_axi_araddr_in == gpifs_pkg::REF_SELECT_OFFSET) begin
        s_axi_rdata_out[1:0] <= {fabric_out.second_pll_manual_ref_select,
                                 fabric_out.first_pll_manual_ref_select};
      end else begin
        s_axi_rresp_out <= gpifs_pkg::RESP_SLVERR;
      end
    end
  end

  // Reserved codes are software's duty; here they simply hold the routed values.
endmodule
`default_nettype wire

// ### testbench/gpifs_pin_drive.sv
// Board-side model that drives the general-purpose pin levels.
// Assumes the bench requests levels on clk_in; each request reaches the pins one edge later.
`timescale 1ns/1ns
`default_nettype none
module gpifs_pin_drive (
  // Clock and requested levels.
  input  wire logic       clk_in,
  input  wire logic [4:0] want_in,
  // Pin levels.
  output var logic  [4:0] pin_out
);
  initial pin_out = 5'h00;
  always @(posedge clk_in) begin
    pin_out <= want_in;
  end
endmodule
`default_nettype wire

// ### testbench/gpifs_properties.sv
// Concurrent checks on the ports of the pin input-function multiplexer.
// Assumes it is bound to gpifs_top and shadows register writes from the bus.
`timescale 1ns/1ns
`default_nettype none
module gpifs_properties (
  // Clock, reset and bus.
  input wire logic                   clk_in,
  input wire logic                   rst_n_in,
  input wire logic [7:0]             s_axi_awaddr_in,
  input wire logic                   s_axi_awvalid_in,
  input wire logic                   s_axi_awready_out,
  input wire logic [31:0]            s_axi_wdata_in,
  input wire logic [3:0]             s_axi_wstrb_in,
  input wire logic                   s_axi_wvalid_in,
  input wire logic                   s_axi_wready_out,
  input wire logic [1:0]             s_axi_bresp_out,
  input wire logic                   s_axi_bvalid_out,
  input wire logic                   s_axi_arvalid_in,
  input wire logic                   s_axi_arready_out,
  input wire logic                   s_axi_rvalid_out,
  // Pins and routed functions.
  input wire logic [4:0]             pin_in,
  input wire gpifs_pkg::gpifs_fabric_t fabric_out
);
  logic [7:0]               a_q;
  logic [32:0]              d_q;
  logic [4:0][2:0]          sel_q;
  logic [4:0]               dir_q;
  logic [4:0]               pin_q;
  logic [4:0]               st_e;
  logic [4:0]               oe_e;
  logic                     live_q;
  gpifs_pkg::gpifs_fabric_t f_q;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sel_q <= '0;
      dir_q <= 5'h00;
      live_q <= 1'b0;
    end else begin
      live_q <= 1'b1;
      if (s_axi_awvalid_in && s_axi_awready_out) a_q <= s_axi_awaddr_in;
      if (s_axi_wvalid_in && s_axi_wready_out) d_q <= {s_axi_wstrb_in[0], s_axi_wdata_in};
      if ($rose(s_axi_bvalid_out) && s_axi_bresp_out == gpifs_pkg::RESP_OKAY && d_q[32]) begin
        if (a_q < 8'h14) sel_q[a_q[4:2]] <= d_q[2:0];
        if (a_q == 8'h14) dir_q <= d_q[4:0];
      end
    end
  end
  always_ff @(posedge clk_in) begin
    pin_q <= pin_in;
    f_q <= fabric_out;
  end
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      st_e[i] = (!dir_q[i] && sel_q[i] == 3'h0) ? pin_q[i] : f_q.pin_input_status_bit[i];
      oe_e[i] = (!dir_q[i] && sel_q[i] == 3'h1) ? pin_q[i] : f_q.clock_output_enable[i];
    end
  end
  property p_status;
    live_q |-> fabric_out.pin_input_status_bit == st_e;
  endproperty
  a_status: assert property (p_status) else $error("status bits not routed");
  property p_oe;
    live_q |-> fabric_out.clock_output_enable == oe_e;
  endproperty
  a_oe: assert property (p_oe) else $error("output enables not routed");
  property p_ref1;
    live_q |-> fabric_out.first_pll_manual_ref_select ==
      ((!dir_q[2] && sel_q[2] == 3'h5) ? pin_q[2] : f_q.first_pll_manual_ref_select);
  endproperty
  a_ref1: assert property (p_ref1) else $error("first reference select wrong");
  property p_ref2;
    live_q |-> fabric_out.second_pll_manual_ref_select ==
      ((!dir_q[3] && sel_q[3] == 3'h5) ? pin_q[3] : f_q.second_pll_manual_ref_select);
  endproperty
  a_ref2: assert property (p_ref2) else $error("second reference select wrong");
  property p_out_mode;
    live_q && dir_q != 5'h00 |-> ((fabric_out.pin_input_status_bit ^ f_q.pin_input_status_bit) & dir_q) == 5'h00
      && ((fabric_out.clock_output_enable ^ f_q.clock_output_enable) & dir_q) == 5'h00;
  endproperty
  a_out_mode: assert property (p_out_mode) else $error("output-mode pin changed a function");
  property p_after_reset;
    live_q && !$past(live_q) |-> fabric_out.pin_input_status_bit == pin_q;
  endproperty
  a_after_reset: assert property (p_after_reset) else $error("pins not plain inputs after reset");
  property p_wlat;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
      |=> s_axi_bvalid_out && !s_axi_awready_out;
  endproperty
  a_wlat: assert property (p_wlat) else $error("write response late");
  property p_rlat;
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out ##1 !s_axi_arready_out || !s_axi_rvalid_out;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read response late");
  c_slverr: cover property ($rose(s_axi_bvalid_out) && s_axi_bresp_out == gpifs_pkg::RESP_SLVERR);
  c_dir: cover property (dir_q != 5'h00);
  c_ref: cover property ($rose(fabric_out.first_pll_manual_ref_select));
endmodule
bind gpifs_top gpifs_properties u_props (.clk_in, .rst_n_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
  .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
  .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out,
  .pin_in, .fabric_out);
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the pin input-function multiplexer.
// Assumes gpifs_top, the pin driver model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk_in;
  logic rst_n_in = 1'b0, s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
  logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
  logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
  logic [31:0] s_axi_wdata_in = 32'h0;
  logic [3:0] s_axi_wstrb_in = 4'h0;
  logic [4:0] want = 5'h00, pin_in, dir_m, st_m, oe_m;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out, r1_m, r2_m;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic [31:0] s_axi_rdata_out, dv;
  logic [2:0] code;
  gpifs_pkg::gpifs_fabric_t fabric_out;
  int n_fail = 0, comparisons = 0, sel_m[5], p;
  gpifs_top uut (.clk_in, .rst_n_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in,
    .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
    .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out,
    .s_axi_rvalid_out, .s_axi_rready_in, .pin_in, .fabric_out);
  gpifs_pin_drive u_pins (.clk_in(clk_in), .want_in(want), .pin_out(pin_in));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (e !== g) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    @(posedge clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_wstrb_in <= s;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do begin
      @(posedge clk_in);
      if (s_axi_awvalid_in && s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wvalid_in && s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
    end while (s_axi_bvalid_out !== 1'b1);
    s_axi_bready_in <= 1'b0;
    chk("bresp", er, s_axi_bresp_out);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do begin
      @(posedge clk_in);
      if (s_axi_arvalid_in && s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
    end while (s_axi_rvalid_out !== 1'b1);
    s_axi_rready_in <= 1'b0;
    chk("rdata", e, s_axi_rdata_out);
    chk("rresp", er, s_axi_rresp_out);
  endtask
  task automatic settle;
    repeat (3) @(posedge clk_in);
    for (int i = 0; i < 5; i++) begin
      if (!dir_m[i] && sel_m[i] == 0) st_m[i] = pin_in[i];
      if (!dir_m[i] && sel_m[i] == 1) oe_m[i] = pin_in[i];
      if (!dir_m[i] && sel_m[i] == 5 && i == 2) r1_m = pin_in[i];
      if (!dir_m[i] && sel_m[i] == 5 && i == 3) r2_m = pin_in[i];
    end
    chk("fabric", {20'h0, st_m, oe_m, r1_m, r2_m}, {20'h0, fabric_out});
  endtask
  task automatic test_done;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    test_done;
  end
  initial begin
    void'($urandom(20360));
    sel_m = '{default: 0};
    {dir_m, st_m, oe_m, r1_m, r2_m} = {10'h000, 5'h1f, 2'h0};
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0, gpifs_pkg::RESP_OKAY);
    rd(8'h14, 32'h0, gpifs_pkg::RESP_OKAY);
    rd(8'h1c, 32'h1f, gpifs_pkg::RESP_OKAY);
    settle;
    wr(8'h00, 32'h5, 4'h0, gpifs_pkg::RESP_OKAY);
    rd(8'h00, 32'h0, gpifs_pkg::RESP_OKAY);
    wr(8'h18, 32'h1f, 4'hf, gpifs_pkg::RESP_OKAY);
    wr(8'h24, 32'h1, 4'hf, gpifs_pkg::RESP_SLVERR);
    rd(8'h24, 32'h0, gpifs_pkg::RESP_SLVERR);
    wr(8'h02, 32'h1, 4'hf, gpifs_pkg::RESP_SLVERR);
    repeat (40) begin
      p = $urandom % 5;
      code = 3'($urandom % 3);
      if (code == 3'h2) code = (p == 2 || p == 3) ? 3'h5 : 3'h0;
      want <= 5'($urandom);
      settle;
      wr(8'(4 * p), {29'h0, code}, 4'hf, gpifs_pkg::RESP_OKAY);
      sel_m[p] = code;
      settle;
      rd(8'(4 * p), {29'h0, code}, gpifs_pkg::RESP_OKAY);
      dv = $urandom & $urandom;
      wr(8'h14, dv, 4'hf, gpifs_pkg::RESP_OKAY);
      dir_m = dv[4:0];
      settle;
      rd(8'h18, {27'h0, st_m}, gpifs_pkg::RESP_OKAY);
      rd(8'h1c, {27'h0, oe_m}, gpifs_pkg::RESP_OKAY);
      rd(8'h20, {30'h0, r2_m, r1_m}, gpifs_pkg::RESP_OKAY);
    end
    test_done;
  end
endmodule
`default_nettype wire
